/* File: design/sopg_top.sv */
// module: sensor output polarity, input indicator and sync gate
`timescale 1ns/10ps
module sopg_top
  import sopg_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic SENSOR_SIG_IN,
  input wire logic EXT_SYNC_IN,
  input wire logic OUT2_INVERTED_POLARITY_IN,
  input wire logic INPUT_INVERTED_POLARITY_IN,
  input wire logic SYNC_INVERTED_POLARITY_IN,
  output logic SENSOR2_OUT,
  output logic SENSOR2_GATED_OUT,
  output logic INPUT_LED_OUT,
  output logic SYNC_LED_OUT
);
  // registered result of each qualifier channel, one bit per channel
  wire logic [NUM_CHAN-1:0] chan_active;

  // gate state seen by the gated copy of the second output
  typedef enum logic [0:0] {
    GATE_BLOCK = 1'h0,
    GATE_PASS = 1'h1
  } sopg_gate_e;

  sopg_gate_e gate_nxt;
  logic out2_nxt;
  logic gated_nxt;

  // per channel the level that drives it and the switch that reads it; the sync
  // channel sees the inverse level, so its qualifier reports permit, not block
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic sel_level;
    logic sel_inverted;

    always_comb begin
      sel_level = 1'h0;
      sel_inverted = POL_NORMAL;
      case (ch)
        CHAN_OUT2: begin
          sel_level = SENSOR_SIG_IN;
          sel_inverted = OUT2_INVERTED_POLARITY_IN;
        end
        CHAN_IN_LED: begin
          sel_level = SENSOR_SIG_IN;
          sel_inverted = INPUT_INVERTED_POLARITY_IN;
        end
        CHAN_SYNC_LED: begin
          sel_level = ~EXT_SYNC_IN;
          sel_inverted = SYNC_INVERTED_POLARITY_IN;
        end
        default: begin
          sel_level = 1'h0;
          sel_inverted = POL_NORMAL;
        end
      endcase
    end

    sopg_pol_sel u_pol_sel (
      .clk_in(CORE_CLK_IN),
      .srst_in(SRST_IN),
      .level_in(sel_level),
      .inverted_polarity_in(sel_inverted),
      .active_out(chan_active[ch])
    );
  end

  assign SENSOR2_OUT = chan_active[CHAN_OUT2];
  assign INPUT_LED_OUT = chan_active[CHAN_IN_LED];
  assign SYNC_LED_OUT = chan_active[CHAN_SYNC_LED];

  // the gated copy decodes the pins again rather than the channel flops, so it
  // moves in the same cycle as the ungated output and the sync indicator
  always_comb begin
    out2_nxt = 1'h0;
    case ({OUT2_INVERTED_POLARITY_IN, SENSOR_SIG_IN})
      {POL_INVERTED, 1'h1}: begin
        out2_nxt = 1'h1;
      end
      {POL_INVERTED, 1'h0}: begin
        out2_nxt = 1'h0;
      end
      {POL_NORMAL, 1'h0}: begin
        out2_nxt = 1'h1;
      end
      {POL_NORMAL, 1'h1}: begin
        out2_nxt = 1'h0;
      end
      default: begin
        out2_nxt = 1'h0;
      end
    endcase
  end

  // an unknown switch or sync level falls to the blocked side
  always_comb begin
    gate_nxt = GATE_BLOCK;
    case ({SYNC_INVERTED_POLARITY_IN, EXT_SYNC_IN})
      {POL_INVERTED, 1'h1}: begin
        gate_nxt = GATE_BLOCK;
      end
      {POL_INVERTED, 1'h0}: begin
        gate_nxt = GATE_PASS;
      end
      {POL_NORMAL, 1'h0}: begin
        gate_nxt = GATE_BLOCK;
      end
      {POL_NORMAL, 1'h1}: begin
        gate_nxt = GATE_PASS;
      end
      default: begin
        gate_nxt = GATE_BLOCK;
      end
    endcase
  end

  // a blocked gate forces the gated output off whatever the sensor level
  always_comb begin
    gated_nxt = 1'h0;
    unique case (gate_nxt)
      GATE_PASS: begin
        gated_nxt = out2_nxt;
      end
      GATE_BLOCK: begin
        gated_nxt = 1'h0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      SENSOR2_GATED_OUT <= OUT_RST_VAL;
    end else begin
      SENSOR2_GATED_OUT <= gated_nxt;
    end
  end
endmodule

/* File: design/sopg_pkg.sv */
// package: polarity encodings and reset values for the sensor output conditioning block
package sopg_pkg;
  localparam logic POL_INVERTED = 1'h1;
  localparam logic POL_NORMAL = 1'h0;
  localparam logic OUT_RST_VAL = 1'h0;
  localparam logic LED_RST_VAL = 1'h0;
  // qualifier channels: second output, input indicator, sync indicator
  localparam int NUM_CHAN = 3;
  localparam int CHAN_OUT2 = 0;
  localparam int CHAN_IN_LED = 1;
  localparam int CHAN_SYNC_LED = 2;
endpackage

/* File: design/sopg_pol_sel.sv */
// module: polarity-selected level qualifier, registered
`timescale 1ns/10ps
module sopg_pol_sel
  import sopg_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic level_in,
  input wire logic inverted_polarity_in,
  output logic active_out
);
  // inverted: active on high level; normal: active on low level
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      active_out <= OUT_RST_VAL;
    end else if (inverted_polarity_in == POL_INVERTED) begin
      active_out <= level_in;
    end else begin
      active_out <= ~level_in;
    end
  end
endmodule

/* File: testbench/sopg_src.sv */
// partner: sensor level and external sync level sources
`timescale 1ns/10ps
module sopg_src(input wire logic [1:0] l_in,output logic s_out,output logic y_out);
  assign {s_out,y_out}=l_in;
endmodule

/* File: testbench/sopg_properties.sv */
// checker: output relations at the block ports
`timescale 1ns/10ps
module sopg_chk(input wire logic CORE_CLK_IN,SRST_IN,SENSOR_SIG_IN,EXT_SYNC_IN,
  OUT2_INVERTED_POLARITY_IN,INPUT_INVERTED_POLARITY_IN,SYNC_INVERTED_POLARITY_IN,
  SENSOR2_OUT,SENSOR2_GATED_OUT,INPUT_LED_OUT,SYNC_LED_OUT);
  logic v,s,e,a,b,c;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);
  // v masks the edge right after reset, whose outputs still hold reset values
  always_ff @(posedge CORE_CLK_IN) {v,s,e,a,b,c}<={!SRST_IN,SENSOR_SIG_IN,EXT_SYNC_IN,
    OUT2_INVERTED_POLARITY_IN,INPUT_INVERTED_POLARITY_IN,SYNC_INVERTED_POLARITY_IN};
  AST_OUT2: assert property(v|->SENSOR2_OUT==(a~^s))else $error("o2");
  AST_INLED: assert property(v|->INPUT_LED_OUT==(b~^s))else $error("led");
  AST_SYNCLED: assert property(v|->SYNC_LED_OUT==(c^e))else $error("sled");
  AST_GATEOFF: assert property(v&&!(c^e)|->!SENSOR2_GATED_OUT)else $error("g");
  AST_GATEON: assert property(v&&(c^e)|->SENSOR2_GATED_OUT==SENSOR2_OUT)else $error("g");
  AST_GATEHOLD: assert property(!SYNC_LED_OUT|->!SENSOR2_GATED_OUT)else $error("gh");
endmodule
bind sopg_top sopg_chk sopg_chk_i(.*);

/* File: testbench/sopg_top_tb.sv */
// bench: sweep of every level and switch setting
`timescale 1ns/10ps
module sopg_top_tb;
  logic c=0,r=1,s,y;
  logic [4:0] k=0;
  logic [3:0] q;
  logic e2,ep;
  // expected second output and gate permit, from the switch settings and source levels
  assign e2=k[2]~^k[4];
  assign ep=k[0]^k[3];
  int err_count=0,checks_done=0,t=0;
  initial forever #4 c=~c;
  always @(posedge c) if(++t>99) begin err_count++; stop_test; end
  sopg_src sopg_src_i(.l_in(k[4:3]),.s_out(s),.y_out(y));
  sopg_top sopg_top_i(.CORE_CLK_IN(c),.SRST_IN(r),.SENSOR_SIG_IN(s),.EXT_SYNC_IN(y),
    .OUT2_INVERTED_POLARITY_IN(k[2]),.INPUT_INVERTED_POLARITY_IN(k[1]),
    .SYNC_INVERTED_POLARITY_IN(k[0]),.SENSOR2_OUT(q[3]),.SENSOR2_GATED_OUT(q[2]),
    .INPUT_LED_OUT(q[1]),.SYNC_LED_OUT(q[0]));
  task stop_test;
    $display("errors %0d checks %0d",err_count,checks_done);
    if(err_count==0&&checks_done>0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n,input logic [3:0] v,e);
    checks_done++;
    if(v!==e) begin
      err_count++;
      $display("Error %s exp %b got %b",n,e,v);
    end
  endtask
  // inputs move every cycle, so each check also proves the one-cycle answer
  task sweep;
    repeat(32) begin
      @(negedge c);
      chk("outs",q,{e2,e2&ep,k[1]~^k[4],ep});
      k++;
    end
  endtask
  // mid-run reset with inputs that would light every output, then close the gate
  task reset_mid;
    @(negedge c);
    k=5'b11110;
    r=1;
    repeat(2) begin
      @(negedge c);
      chk("reset outs",q,4'h0);
    end
    r=0;
    @(negedge c);
    chk("release outs",q,4'hF);
    k=5'b10110;
    @(negedge c);
    chk("gate closed",q,4'hA);
  endtask
  initial begin
    repeat(12) @(negedge c);
    r=0;
    sweep;
    reset_mid;
    stop_test;
  end
endmodule
